// ---- hdl/asc_pkg.sv ----
// shared constants and types of the converter serial command port
package asc_pkg;
    // frame layout
    localparam int WORD_BITS = 32;
    localparam int CMD_BITS = 13;
    localparam logic [5:0] CNT_PREFIX_LAST = 6'h03;
    localparam logic [5:0] CNT_CMD_LAST = 6'h0d;
    localparam logic [5:0] CNT_WORD_LAST = 6'h20;
    localparam int RESULT_BITS = 30;
    // command field positions inside the 13-bit command
    localparam int CMD_PREFIX_MSB = 12;
    localparam int CMD_PREFIX_LSB = 10;
    localparam int CMD_CHAN_MSB = 9;
    localparam int CMD_CHAN_LSB = 5;
    localparam int CMD_SPEED_MSB = 4;
    localparam int CMD_SPEED_LSB = 0;
    localparam logic [2:0] PREFIX_UPDATE = 3'h5;
    // channel select field positions
    localparam int SEL_SINGLE_BIT = 4;
    localparam int SEL_ODD_BIT = 3;
    localparam logic [4:0] COMMON_CHAN = 5'h10;
    // power-up settings: pair 0/1, ratio code for 256, normal rate
    localparam logic [4:0] RST_CHAN_SEL = 5'h00;
    localparam logic [3:0] RST_OSR_CODE = 4'h3;
    localparam logic RST_RATE_DOUBLER = 1'h0;
    // oversample ratio codes
    localparam logic [3:0] OSR_CODE_MIN = 4'h1;
    localparam logic [3:0] OSR_CODE_LINEAR_MAX = 4'h9;
    localparam logic [3:0] OSR_CODE_TOP = 4'hf;
    localparam logic [3:0] OSR_SHIFT_TOP = 4'h9;
    localparam logic [15:0] OSR_BASE = 16'h0040;
    // timing
    localparam int CLOCK_HZ = 25000000;
    localparam int SCK_HALF_CYCLES = 1;
    localparam int CONV_UNIT_CYCLES = 4;

    typedef enum logic [1:0] {ST_CONVERT, ST_SLEEP, ST_DATA_OUT} asc_state_t;
endpackage

// ---- hdl/asc_sync2.sv ----
// two-flop level synchroniser, one bit per lane
`timescale 1ns/1ns
module asc_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // levels in and out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } asc_sync_t;

    asc_sync_t s_reg;
    asc_sync_t s_next;

    // first stage feeds the second stage only
    always_comb begin
        s_next.meta = d;
        s_next.stable = s_reg.meta;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign q = s_reg.stable;
endmodule

// ---- hdl/asc_sck_gen.sv ----
// serial clock generator for the device-driven clock mode
`timescale 1ns/1ns
module asc_sck_gen #(
    parameter int HALF = asc_pkg::SCK_HALF_CYCLES,
    parameter int PULSES = asc_pkg::WORD_BITS
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // control
    input wire logic enable,
    input wire logic clear,
    // generated clock
    output logic sck_out
);
    typedef struct packed {
        logic [7:0] div;
        logic [6:0] pulses;
        logic level;
    } asc_gen_t;

    asc_gen_t g_reg;
    asc_gen_t g_next;

    // one half period per HALF cycles; stops low after the last falling edge
    always_comb begin
        g_next = g_reg;
        if (clear) begin
            g_next = '0;
        end else if (!enable) begin
            g_next.level = 1'b0;
            g_next.div = '0;
        end else if (g_reg.div != 8'(HALF - 1)) begin
            g_next.div = g_reg.div + 8'h01;
        end else begin
            g_next.div = '0;
            if (g_reg.level) begin
                g_next.level = 1'b0;
            end else if (g_reg.pulses != 7'(PULSES)) begin
                g_next.level = 1'b1;
                g_next.pulses = g_reg.pulses + 7'h01;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            g_reg <= '0;
        end else begin
            g_reg <= g_next;
        end
    end

    assign sck_out = g_reg.level;
endmodule

// ---- hdl/asc_serial_port.sv ----
// serial port, command decoder and conversion sequencer of the converter
`timescale 1ns/1ns
// Notes on behaviour
// - output data changes to the next bit on each falling serial clock edge
// - internal mode drives the clock pin; external mode takes it from the host
// - strap low selects host clock, strap high selects device clock
// - data output state sends the latest result, most significant bit first
// - data output driver released while chip select is high
// - with chip select low, output shows end flag: high converting, low done
// - sleep lasts until first rising serial clock with chip select low
// - chip select rising in data output aborts and starts a new conversion
// - first conversion uses pair 0/1, ratio 256, normal rate
// - every conversion ends in sleep, ready to send and take a command
// - only prefix 101 updates channel and speed
// - prefixes 000 and 100 ignore the rest and keep settings
// - after 101, five channel bits then five speed bits
// - all-zero speed field keeps speed but applies the channel
// - first channel bit: 0 differential, 1 single-ended against common
// - four channel bits pick the channel; eight-channel hosts keep bit2 zero
// - differential selects pair 2n, 2n+1; odd bit swaps polarity
// - single-ended positive input is 2 times address plus odd bit
// - word: end flag, zero filler, sign, 24 result bits, 5 sub bits
// - falling edge of pulse 32 drives output high for the next conversion
// - speed field: four ratio bits from 64 to 32768, last bit doubles rate
module asc_serial_port #(
    parameter int CONV_UNIT = asc_pkg::CONV_UNIT_CYCLES,
    parameter int SCK_HALF = asc_pkg::SCK_HALF_CYCLES
) (
    // core clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // strap
    input wire logic clock_source_strap,
    // serial pins
    input wire logic cs_n,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic sdi,
    output logic sdo_out,
    output logic sdo_oe,
    // conversion engine side
    input wire logic [asc_pkg::RESULT_BITS-1:0] conv_result,
    output logic conv_active,
    output logic conv_start,
    output logic [4:0] pos_input,
    output logic [4:0] neg_input,
    output logic [15:0] oversample_ratio,
    output logic rate_doubler
);
    typedef struct packed {
        asc_pkg::asc_state_t state;
        logic [19:0] conv_cnt;
        logic [asc_pkg::RESULT_BITS-1:0] result;
        logic [4:0] chan_sel;
        logic [3:0] osr_code;
        logic rate2x;
        logic pend_valid;
        logic [asc_pkg::CMD_BITS-1:0] pend_cmd;
        logic [2:0] tgl_seen;
        logic cs_n_prev;
        logic link_rst_n;
        logic start;
    } asc_core_t;

    asc_core_t c_reg;
    asc_core_t c_next;

    // link-side state on the serial clock
    logic [5:0] bit_cnt_reg;
    logic [asc_pkg::CMD_BITS-1:0] cmd_reg;
    logic start_tgl_reg;
    logic cmd_tgl_reg;
    logic done_tgl_reg;
    logic sdo_bit_reg;
    logic shifting_reg;

    // crossing into the core domain
    logic [4:0] sync_q;
    logic cs_n_sync;
    logic strap_sync;
    logic [2:0] tgl_sync;
    logic [2:0] tgl_event;

    logic eoc_n;
    logic gen_enable;
    logic gen_clear;
    logic [asc_pkg::WORD_BITS-1:0] out_word;
    logic [4:0] out_idx;
    logic [4:0] shift_amt;
    logic [2:0] prefix;
    logic [4:0] chan_field;
    logic [4:0] speed_field;
    logic [asc_pkg::CMD_BITS-1:0] cmd_now;
    logic cmd_now_valid;
    logic frame_end;

    asc_sync2 #(
        .W(5)
    ) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .d({clock_source_strap, done_tgl_reg, cmd_tgl_reg, start_tgl_reg, cs_n}),
        .q(sync_q)
    );

    assign cs_n_sync = sync_q[0];
    assign tgl_sync = sync_q[3:1];
    assign strap_sync = sync_q[4];
    assign tgl_event = tgl_sync ^ c_reg.tgl_seen;

    // the device clock runs only while a result is waiting or being read
    assign gen_enable = strap_sync && !cs_n_sync
        && (c_reg.state != asc_pkg::ST_CONVERT);
    assign gen_clear = cs_n_sync || (c_reg.state == asc_pkg::ST_CONVERT);

    asc_sck_gen #(
        .HALF(SCK_HALF),
        .PULSES(asc_pkg::WORD_BITS)
    ) u_sck_gen (
        .clock(clock),
        .rst_n(rst_n),
        .enable(gen_enable),
        .clear(gen_clear),
        .sck_out(sck_out)
    );

    // pin direction follows the strap: high drives the clock, low listens
    assign sck_oe = strap_sync;

    // frame bit counter, cleared by chip select high so an abort needs no clock
    always_ff @(posedge sck_in or posedge cs_n) begin
        if (cs_n) begin
            bit_cnt_reg <= '0;
        end else if (bit_cnt_reg != asc_pkg::CNT_WORD_LAST) begin
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
        end
    end

    // command capture and event toggles; toggles survive chip select
    always_ff @(posedge sck_in or negedge c_reg.link_rst_n) begin
        if (!c_reg.link_rst_n) begin
            cmd_reg <= '0;
            start_tgl_reg <= 1'b0;
            cmd_tgl_reg <= 1'b0;
            done_tgl_reg <= 1'b0;
        end else if (!cs_n) begin
            if (bit_cnt_reg == 6'h00) begin
                start_tgl_reg <= !start_tgl_reg;
            end
            if (bit_cnt_reg < asc_pkg::CNT_CMD_LAST) begin
                cmd_reg <= {cmd_reg[asc_pkg::CMD_BITS-2:0], sdi};
            end
            if (bit_cnt_reg == asc_pkg::CNT_CMD_LAST - 6'h01) begin
                cmd_tgl_reg <= !cmd_tgl_reg;
            end
            if (bit_cnt_reg == asc_pkg::CNT_WORD_LAST - 6'h01) begin
                done_tgl_reg <= !done_tgl_reg;
            end
        end
    end

    // result word, stable through sleep and data output, so the link reads it directly
    assign out_word = {1'b0, 1'b0, c_reg.result};
    assign out_idx = 5'h1f - bit_cnt_reg[4:0];

    // output bit moves on the falling edge; bit 31 already stands before the first
    always_ff @(negedge sck_in or posedge cs_n) begin
        if (cs_n) begin
            sdo_bit_reg <= 1'b0;
            shifting_reg <= 1'b0;
        end else if (bit_cnt_reg != 6'h00) begin
            shifting_reg <= 1'b1;
            if (bit_cnt_reg == asc_pkg::CNT_WORD_LAST) begin
                sdo_bit_reg <= 1'b1;
            end else begin
                sdo_bit_reg <= out_word[out_idx];
            end
        end
    end

    // end flag is high only while converting
    assign eoc_n = (c_reg.state == asc_pkg::ST_CONVERT);
    // a clocking host during conversion only ever sees the flag
    assign sdo_out = eoc_n | (shifting_reg & sdo_bit_reg);
    assign sdo_oe = !cs_n;

    // command fields of a command arriving this cycle or held from earlier
    assign cmd_now_valid = c_reg.pend_valid
        || (tgl_event[1] && c_reg.state == asc_pkg::ST_DATA_OUT);
    assign cmd_now = tgl_event[1] ? cmd_reg : c_reg.pend_cmd;
    assign prefix = cmd_now[asc_pkg::CMD_PREFIX_MSB:asc_pkg::CMD_PREFIX_LSB];
    assign chan_field = cmd_now[asc_pkg::CMD_CHAN_MSB:asc_pkg::CMD_CHAN_LSB];
    assign speed_field = cmd_now[asc_pkg::CMD_SPEED_MSB:asc_pkg::CMD_SPEED_LSB];
    assign frame_end = tgl_event[2] || (cs_n_sync && !c_reg.cs_n_prev);

    // conversion length scales with the ratio; doubled rate halves it
    always_comb begin
        if (c_reg.osr_code == asc_pkg::OSR_CODE_TOP) begin
            shift_amt = {1'b0, asc_pkg::OSR_SHIFT_TOP};
        end else begin
            shift_amt = {1'b0, c_reg.osr_code - asc_pkg::OSR_CODE_MIN};
        end
    end

    // sequencer: convert, sleep, data output
    always_comb begin
        c_next = c_reg;
        c_next.start = 1'b0;
        c_next.link_rst_n = 1'b1;
        c_next.cs_n_prev = cs_n_sync;
        c_next.tgl_seen = tgl_sync;
        unique case (c_reg.state)
            asc_pkg::ST_CONVERT: begin
                c_next.pend_valid = 1'b0;
                if (c_reg.conv_cnt == 20'h00001) begin
                    c_next.result = conv_result;
                    c_next.state = asc_pkg::ST_SLEEP;
                end else begin
                    c_next.conv_cnt = c_reg.conv_cnt - 20'h00001;
                end
            end
            asc_pkg::ST_SLEEP: begin
                if (tgl_event[0]) begin
                    c_next.state = asc_pkg::ST_DATA_OUT;
                end
            end
            asc_pkg::ST_DATA_OUT: begin
                if (tgl_event[1]) begin
                    c_next.pend_cmd = cmd_reg;
                    c_next.pend_valid = 1'b1;
                end
                if (frame_end) begin
                    c_next.state = asc_pkg::ST_CONVERT;
                    c_next.start = 1'b1;
                    if (cmd_now_valid && prefix == asc_pkg::PREFIX_UPDATE) begin
                        c_next.chan_sel = chan_field;
                        if (speed_field[4:1] != 4'h0
                            && (speed_field[4:1] <= asc_pkg::OSR_CODE_LINEAR_MAX
                            || speed_field[4:1] == asc_pkg::OSR_CODE_TOP)) begin
                            c_next.osr_code = speed_field[4:1];
                            c_next.rate2x = speed_field[0];
                        end else if (speed_field[4:1] == 4'h0 && speed_field[0]) begin
                            c_next.rate2x = 1'b1;
                        end
                    end
                    c_next.pend_valid = 1'b0;
                end
            end
        endcase
        // reload the timer when a conversion is launched, from the new settings
        if (c_next.start) begin
            c_next.conv_cnt = 20'((CONV_UNIT << conv_shift(c_next.osr_code))
                >> c_next.rate2x);
        end
    end

    // shift amount for a ratio code, used when reloading the timer
    function automatic logic [4:0] conv_shift(input logic [3:0] code);
        if (code == asc_pkg::OSR_CODE_TOP) begin
            conv_shift = {1'b0, asc_pkg::OSR_SHIFT_TOP};
        end else begin
            conv_shift = {1'b0, code - asc_pkg::OSR_CODE_MIN};
        end
    endfunction

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            c_reg <= '0;
            c_reg.state <= asc_pkg::ST_CONVERT;
            c_reg.chan_sel <= asc_pkg::RST_CHAN_SEL;
            c_reg.osr_code <= asc_pkg::RST_OSR_CODE;
            c_reg.rate2x <= asc_pkg::RST_RATE_DOUBLER;
            c_reg.conv_cnt <= 20'(CONV_UNIT << 2);
            c_reg.cs_n_prev <= 1'b1;
            c_reg.start <= 1'b1;
        end else begin
            c_reg <= c_next;
        end
    end

    // input selection: pair 2n/2n+1, or channel 2n+odd against common
    always_comb begin
        if (c_reg.chan_sel[asc_pkg::SEL_SINGLE_BIT]) begin
            pos_input = {1'b0, c_reg.chan_sel[2:0], c_reg.chan_sel[3]};
            neg_input = asc_pkg::COMMON_CHAN;
        end else begin
            pos_input = {1'b0, c_reg.chan_sel[2:0], c_reg.chan_sel[3]};
            neg_input = {1'b0, c_reg.chan_sel[2:0], !c_reg.chan_sel[3]};
        end
    end

    // ratio value: 64 doubled per code step up to code 9; code 15 gives 32768
    assign oversample_ratio = asc_pkg::OSR_BASE << shift_amt;
    assign rate_doubler = c_reg.rate2x;
    assign conv_active = eoc_n;
    assign conv_start = c_reg.start;
endmodule

// ---- tb/asc_serial_port_checker.sv ----
// concurrent checks on the converter serial port pins
`timescale 1ns/1ns
module asc_serial_port_checker (
    // clocks and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic sck_in,
    // serial pins
    input wire logic clock_source_strap,
    input wire logic cs_n,
    input wire logic sck_oe,
    input wire logic sdo_out,
    input wire logic sdo_oe,
    // conversion side
    input wire logic conv_active,
    input wire logic conv_start,
    input wire logic [4:0] pos_input,
    input wire logic [4:0] neg_input,
    input wire logic [15:0] oversample_ratio,
    input wire logic rate_doubler
);
    // core domain checks
    a_sdo_release: assert property (@(posedge clock) disable iff (!rst_n)
        sdo_oe == !cs_n) else $error("data driver enable does not follow select");
    a_eoc_busy: assert property (@(posedge clock) disable iff (!rst_n)
        !cs_n && conv_active |-> sdo_out) else $error("end flag low while converting");
    a_eoc_done: assert property (@(posedge clock) disable iff (!rst_n)
        !cs_n && $fell(conv_active) |-> !sdo_out) else $error("end flag high when done");
    // strap goes through two sync flops, so allow four cycles
    a_clk_int: assert property (@(posedge clock) disable iff (!rst_n)
        clock_source_strap [*4] |-> sck_oe) else $error("clock pin not driven");
    a_clk_ext: assert property (@(posedge clock) disable iff (!rst_n)
        !clock_source_strap [*4] |-> !sck_oe) else $error("clock pin driven");
    a_start_pulse: assert property (@(posedge clock) disable iff (!rst_n)
        conv_start |=> !conv_start && conv_active) else $error("start pulse malformed");
    a_set_hold: assert property (@(posedge clock) disable iff (!rst_n)
        conv_active [*4] |-> $stable({pos_input, neg_input, oversample_ratio, rate_doubler}))
        else $error("settings moved during a conversion");
    a_ratio_code: assert property (@(posedge clock) disable iff (!rst_n)
        $onehot(oversample_ratio) && oversample_ratio[5:0] == 6'h00)
        else $error("ratio outside the coded set");
    a_input_pair: assert property (@(posedge clock) disable iff (!rst_n)
        !pos_input[4] && (neg_input == asc_pkg::COMMON_CHAN || neg_input == (pos_input ^ 5'h01)))
        else $error("input pair not legal");
    // link domain: clock edges during a conversion must not shift data out
    a_link_busy: assert property (@(posedge sck_in) disable iff (!rst_n || cs_n)
        conv_active |-> sdo_out) else $error("data moved during conversion");
    // main scenarios
    c_frame: cover property (@(posedge clock) disable iff (!rst_n) $rose(conv_active));
    c_poll: cover property (@(posedge clock) disable iff (!rst_n) !cs_n && conv_active);
    c_internal: cover property (@(posedge clock) disable iff (!rst_n) sck_oe && !cs_n);
endmodule

// ---- tb/asc_host_model.sv ----
// host side model: chip select, serial clock and command data
`timescale 1ns/1ns
module asc_host_model (
    // core clock, only to align chip select changes
    input wire logic clock,
    // serial pins
    output logic sck_drv,
    input wire logic sck_wire,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo,
    // high while the host makes the serial clock
    input wire logic ext_clk
);
    // idle pins; the clock stands still outside frames
    initial begin
        sck_drv = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    // chip select alone, for status polling
    task automatic set_cs(input logic v);
        @(posedge clock);
        cs_n <= v;
    endtask
    // one transfer of n pulses, 30 ns each with host clock; gap delays the first edge
    task automatic frame(input logic [12:0] c, input int n, input int gap,
                         output logic [31:0] w, output logic tail);
        w = 32'h0;
        sdi = c[12];
        set_cs(1'b0);
        #(gap);
        for (int k = 0; k < n; k++) begin
            sdi = (k < 13) ? c[12 - k] : 1'b0;
            if (ext_clk) begin
                #15 sck_drv = 1'b1;
            end else begin
                @(posedge sck_wire);
            end
            #1 w = {w[30:0], sdo};
            if (ext_clk) begin
                #14 sck_drv = 1'b0;
            end else begin
                @(negedge sck_wire);
            end
        end
        #5 tail = sdo;
        sdi = ~sdi; // released data line must not keep its last value
        set_cs(1'b1);
    endtask
endmodule

// ---- tb/asc_serial_port_tb_top.sv ----
// testbench for the converter serial command port
`timescale 1ns/1ns
module asc_serial_port_tb_top;
    logic clock;
    logic rst_n;
    logic strap;
    logic [asc_pkg::RESULT_BITS-1:0] conv_result;
    logic sck_h, sck_w, cs_n, sdi, sdo_w;
    logic sck_out, sck_oe, sdo_out, sdo_oe, conv_active, conv_start, rate_doubler;
    logic [4:0] pos_input, neg_input, e_pos, e_neg;
    logic [15:0] oversample_ratio, e_ratio;
    logic e_rate;
    logic [26:0] cur_set, exp_set;
    int error_cnt, samples_checked;
    int cycle_cnt = 0;
    logic [12:0] cmds [6] = '{13'h157f, 13'h03e2, 13'h1202, 13'h17a0, 13'h1402, 13'h16f2};

    // wires: the clock pin belongs to whoever is enabled
    assign sck_w = sck_oe ? sck_out : sck_h;
    assign sdo_w = sdo_oe ? sdo_out : !sdo_out;
    assign cur_set = {pos_input, neg_input, oversample_ratio, rate_doubler};
    assign exp_set = {e_pos, e_neg, e_ratio, e_rate};

    asc_serial_port #(.CONV_UNIT(4), .SCK_HALF(1)) i_asc_serial_port (
        .clock(clock), .rst_n(rst_n), .clock_source_strap(strap), .cs_n(cs_n),
        .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe), .sdi(sdi), .sdo_out(sdo_out),
        .sdo_oe(sdo_oe), .conv_result(conv_result), .conv_active(conv_active),
        .conv_start(conv_start), .pos_input(pos_input), .neg_input(neg_input),
        .oversample_ratio(oversample_ratio), .rate_doubler(rate_doubler));

    asc_host_model i_asc_host_model (.clock(clock), .sck_drv(sck_h), .sck_wire(sck_w),
        .cs_n(cs_n), .sdi(sdi), .sdo(sdo_w), .ext_clk(!strap));

    // core clock and hang guard
    always #20 clock = ~clock;
    always @(posedge clock) begin
        cycle_cnt++;
        if (cycle_cnt == 60000) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected value at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // bounded wait for the conversion flag
    task automatic wait_conv(input logic lvl);
        for (int n = 0; n < 3000 && conv_active !== lvl; n++) begin
            @(posedge clock);
        end
        @(negedge clock);
    endtask

    // expected settings after a full command, worked out from the field layout
    task automatic expect_cmd(input logic [12:0] c);
        if (c[12:10] == 3'b101) begin
            e_pos = {1'b0, c[7:5], c[8]};
            e_neg = c[9] ? 5'h10 : {1'b0, c[7:5], !c[8]};
            if (c[4:1] >= 4'h1 && c[4:1] <= 4'h9) e_ratio = 16'h0040 << (c[4:1] - 4'h1);
            if (c[4:1] == 4'hf) e_ratio = 16'h8000;
            if (c[4:0] != 5'h00) e_rate = c[0];
        end
    endtask

    // one transfer; short ones are aborts and must leave settings alone
    task automatic run_frame(input logic [12:0] c, input int n, input int gap);
        logic [31:0] w;
        logic tail;
        wait_conv(1'b0);
        repeat (4) @(posedge clock);
        i_asc_host_model.frame(c, n, gap, w, tail);
        if (n == 32) begin
            chk(w, 32'h2fff0001);
            chk(tail, 1'b1);
            expect_cmd(c);
        end
        wait_conv(1'b1);
        chk(conv_active, 1'b1);
        repeat (3) @(negedge clock);
        chk(cur_set, exp_set);
    endtask

    // status polling while converting, then sleep with no clock
    task automatic t_poll();
        i_asc_host_model.set_cs(1'b0);
        repeat (2) @(negedge clock);
        chk({conv_active, sdo_oe, sdo_w}, 3'b111);
        wait_conv(1'b0);
        repeat (3) @(negedge clock);
        chk(sdo_w, 1'b0);
        repeat (20) @(negedge clock);
        chk(conv_active, 1'b0);
        i_asc_host_model.set_cs(1'b1);
        repeat (4) @(negedge clock);
        chk({conv_active, sdo_oe}, 2'b00);
    endtask

    // main sequence
    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        strap = 1'b0;
        conv_result = 30'h2fff0001;
        error_cnt = 0;
        samples_checked = 0;
        {e_pos, e_neg, e_ratio, e_rate} = {5'h00, 5'h01, 16'h0100, 1'b0};
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(negedge clock);
        chk(cur_set, exp_set);
        chk({sdo_oe, sck_oe}, 2'b00);
        t_poll();
        foreach (cmds[i]) begin
            run_frame(cmds[i], 32, (i % 2) * 300);
        end
        run_frame(13'h157f, 8, 0);
        @(posedge clock);
        strap <= 1'b1;
        repeat (6) @(negedge clock);
        chk(sck_oe, 1'b1);
        run_frame(13'h1486, 32, 0);
        test_done();
    end
endmodule

bind asc_serial_port asc_serial_port_checker i_asc_serial_port_checker (
    .clock(clock), .rst_n(rst_n), .sck_in(sck_in), .clock_source_strap(clock_source_strap),
    .cs_n(cs_n), .sck_oe(sck_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .conv_active(conv_active), .conv_start(conv_start), .pos_input(pos_input),
    .neg_input(neg_input), .oversample_ratio(oversample_ratio), .rate_doubler(rate_doubler));
